// [verilog/ipse_pkg.sv]
// package: constants for the press and sensor event block
package ipse_pkg;
  localparam int IPSE_TICK_NS = 1000000;
  localparam int IPSE_CLK_NS = 10;
  localparam int IPSE_TICK_CYC = IPSE_TICK_NS / IPSE_CLK_NS;
  localparam int IPSE_TAP_MAX_MS = 500;
  localparam int IPSE_BRIEF_MAX_MS = 2000;
  localparam int IPSE_EXT_MAX_MS = 5000;
  localparam int IPSE_NUM_INPUTS = 2;
  localparam int IPSE_NUM_SENSORS = 4;
  localparam int IPSE_VAL_W = 16;
  localparam int IPSE_MS_W = 16;
  localparam logic [15:0] IPSE_SHORT_VALUE = 16'h0000;
  localparam logic [15:0] IPSE_HOLD_WAIT_RST = 16'h03e8;
  localparam logic [15:0] IPSE_HOLD_PERIOD_RST = 16'h01f4;
endpackage

// [verilog/ipse_contact.sv]
// one contact input channel: edge, duration and held events
module ipse_contact
  import ipse_pkg::*;
(
  // clock and reset
  input wire logic i_core_clk,
  input wire logic i_arst_n,
  // inputs
  input wire logic i_ms_tick,
  input wire logic i_level,
  input wire logic [IPSE_MS_W-1:0] i_hold_wait_time,
  input wire logic [IPSE_MS_W-1:0] i_hold_repeat_period,
  // events
  output logic o_tap_event,
  output logic o_brief_press_event,
  output logic o_extended_press_event,
  output logic o_held_event,
  output logic o_input_high_event,
  output logic o_input_low_event
);
  logic level_r;
  logic [IPSE_MS_W-1:0] dur_r;
  logic [IPSE_MS_W-1:0] hold_r;
  logic held_seen_r;
  logic rise;
  logic fall;
  assign rise = i_level & ~level_r;
  assign fall = ~i_level & level_r;

  always_ff @(posedge i_core_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      level_r <= 1'b0;
    end else begin
      level_r <= i_level;
    end
  end

  // press duration, saturating so very long presses stay long
  always_ff @(posedge i_core_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      dur_r <= '0;
    end else if (rise) begin
      dur_r <= '0;
    end else if (level_r && i_ms_tick && dur_r != '1) begin
      dur_r <= dur_r + 1'b1;
    end
  end

  // held wait then repeating period
  always_ff @(posedge i_core_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      hold_r <= '0;
      held_seen_r <= 1'b0;
      o_held_event <= 1'b0;
    end else begin
      o_held_event <= 1'b0;
      if (rise || !level_r) begin
        hold_r <= '0;
        held_seen_r <= 1'b0;
      end else if (i_ms_tick) begin
        if ((!held_seen_r && hold_r + 1'b1 >= i_hold_wait_time) ||
            (held_seen_r && hold_r + 1'b1 >= i_hold_repeat_period)) begin
          o_held_event <= 1'b1;
          held_seen_r <= 1'b1;
          hold_r <= '0;
        end else begin
          hold_r <= hold_r + 1'b1;
        end
      end
    end
  end

  always_ff @(posedge i_core_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      o_input_high_event <= 1'b0;
      o_input_low_event <= 1'b0;
      o_tap_event <= 1'b0;
      o_brief_press_event <= 1'b0;
      o_extended_press_event <= 1'b0;
    end else begin
      o_input_high_event <= rise;
      o_input_low_event <= fall;
      o_tap_event <= fall && dur_r < IPSE_MS_W'(IPSE_TAP_MAX_MS);
      o_brief_press_event <= fall && dur_r >= IPSE_MS_W'(IPSE_TAP_MAX_MS)
        && dur_r < IPSE_MS_W'(IPSE_BRIEF_MAX_MS);
      o_extended_press_event <= fall && dur_r >= IPSE_MS_W'(IPSE_BRIEF_MAX_MS)
        && dur_r <= IPSE_MS_W'(IPSE_EXT_MAX_MS);
    end
  end

  a_low_event_edge: assert property (@(posedge i_core_clk) disable iff (!i_arst_n)
    o_input_low_event |-> $past(level_r) && !$past(i_level))
    else $error("low event without falling input");
endmodule

// [verilog/ipse_sensor.sv]
// one temperature sensor channel: value hold and limit events
module ipse_sensor
  import ipse_pkg::*;
(
  // clock and reset
  input wire logic i_core_clk,
  input wire logic i_arst_n,
  // reading
  input wire logic i_valid,
  input wire logic [IPSE_VAL_W-1:0] i_value,
  input wire logic i_short,
  input wire logic i_present,
  input wire logic [IPSE_VAL_W-1:0] i_lower_limit,
  input wire logic [IPSE_VAL_W-1:0] i_upper_limit,
  input wire logic [IPSE_VAL_W-1:0] i_hyst_low,
  input wire logic [IPSE_VAL_W-1:0] i_hyst_high,
  // results
  output logic [IPSE_VAL_W-1:0] o_value,
  output logic o_value_changed_event,
  output logic o_rising_crossing_event,
  output logic o_falling_crossing_event,
  output logic o_out_of_limits_event,
  output logic o_back_in_limits_event
);
  logic outside_r;
  logic above_r;
  logic below_r;
  logic upd;
  logic [IPSE_VAL_W-1:0] v;
  logic out_now;
  // a lost sensor sends no reading, so the last one simply stays
  assign upd = i_valid || (i_short && i_present);
  assign v = i_short ? IPSE_SHORT_VALUE : i_value;
  assign out_now = (v < i_lower_limit) || (v > i_upper_limit);

  always_ff @(posedge i_core_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      o_value <= '0;
      outside_r <= 1'b0;
      above_r <= 1'b0;
      below_r <= 1'b0;
      o_value_changed_event <= 1'b0;
      o_rising_crossing_event <= 1'b0;
      o_falling_crossing_event <= 1'b0;
      o_out_of_limits_event <= 1'b0;
      o_back_in_limits_event <= 1'b0;
    end else begin
      o_value_changed_event <= upd && v != o_value;
      o_rising_crossing_event <= upd && !above_r && v > i_hyst_high;
      o_falling_crossing_event <= upd && !below_r && v < i_hyst_low;
      o_out_of_limits_event <= upd && !outside_r && out_now;
      o_back_in_limits_event <= upd && outside_r && !out_now;
      if (upd) begin
        o_value <= v;
        outside_r <= out_now;
        above_r <= v > i_hyst_high;
        below_r <= v < i_hyst_low;
      end
    end
  end

  a_short_reads_zero: assert property (@(posedge i_core_clk) disable iff (!i_arst_n)
    i_short && i_present |=> o_value == IPSE_SHORT_VALUE)
    else $error("short did not report zero");
  a_value_held_lost: assert property (@(posedge i_core_clk) disable iff (!i_arst_n)
    !i_valid && !i_short |=> $stable(o_value))
    else $error("value changed without reading");
endmodule

// [verilog/ipse_top.sv]
// top: contact inputs and temperature sensor channels with event outputs
module ipse_top
  import ipse_pkg::*;
#(
  parameter int TICK_CYC = IPSE_TICK_CYC
)
(
  // clock and reset
  input wire logic i_core_clk,
  input wire logic i_arst_n,
  // contact inputs (pins)
  input wire logic [IPSE_NUM_INPUTS-1:0] i_contact_input_channel,
  input wire logic [IPSE_MS_W-1:0] i_hold_wait_time,
  input wire logic [IPSE_MS_W-1:0] i_hold_repeat_period,
  // sensor readings from the bus controller
  input wire logic [IPSE_NUM_SENSORS-1:0] i_sensor_valid,
  input wire logic [IPSE_NUM_SENSORS*IPSE_VAL_W-1:0] i_sensor_value,
  input wire logic i_bus_short,
  input wire logic i_discovery_strobe,
  input wire logic [IPSE_NUM_SENSORS-1:0] i_discovery_present,
  input wire logic [IPSE_VAL_W-1:0] i_lower_limit,
  input wire logic [IPSE_VAL_W-1:0] i_upper_limit,
  input wire logic [IPSE_VAL_W-1:0] i_hyst_low,
  input wire logic [IPSE_VAL_W-1:0] i_hyst_high,
  // contact events
  output logic [IPSE_NUM_INPUTS-1:0] o_tap_event,
  output logic [IPSE_NUM_INPUTS-1:0] o_brief_press_event,
  output logic [IPSE_NUM_INPUTS-1:0] o_extended_press_event,
  output logic [IPSE_NUM_INPUTS-1:0] o_held_event,
  output logic [IPSE_NUM_INPUTS-1:0] o_input_high_event,
  output logic [IPSE_NUM_INPUTS-1:0] o_input_low_event,
  output logic [IPSE_NUM_INPUTS-1:0] o_contact_level,
  // sensor results
  output logic [IPSE_NUM_SENSORS-1:0] o_discovered,
  output logic [IPSE_NUM_SENSORS*IPSE_VAL_W-1:0] o_sensor_value,
  output logic [IPSE_NUM_SENSORS-1:0] o_value_changed_event,
  output logic [IPSE_NUM_SENSORS-1:0] o_rising_crossing_event,
  output logic [IPSE_NUM_SENSORS-1:0] o_falling_crossing_event,
  output logic [IPSE_NUM_SENSORS-1:0] o_out_of_limits_event,
  output logic [IPSE_NUM_SENSORS-1:0] o_back_in_limits_event
);
  import ipse_pkg::*;

  // a divider below one can never produce a millisecond tick
  if (TICK_CYC < 1) begin : g_bad_tick
    $error("TICK_CYC must be at least 1");
  end

  // ----------------------------------------
  // pin synchronisers and millisecond tick
  // ----------------------------------------
  logic [IPSE_NUM_INPUTS-1:0] sync1_r;
  logic [IPSE_NUM_INPUTS-1:0] sync2_r;
  logic [31:0] tick_cnt_r;
  logic ms_tick_r;

  always_ff @(posedge i_core_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      sync1_r <= '0;
      sync2_r <= '0;
    end else begin
      sync1_r <= i_contact_input_channel;
      sync2_r <= sync1_r;
    end
  end

  always_ff @(posedge i_core_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      tick_cnt_r <= '0;
      ms_tick_r <= 1'b0;
    end else if (tick_cnt_r == 32'(TICK_CYC - 1)) begin
      tick_cnt_r <= '0;
      ms_tick_r <= 1'b1;
    end else begin
      tick_cnt_r <= tick_cnt_r + 32'h0000_0001;
      ms_tick_r <= 1'b0;
    end
  end

  always_ff @(posedge i_core_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      o_contact_level <= '0;
    end else begin
      o_contact_level <= sync2_r;
    end
  end

  // ----------------------------------------
  // contact channels
  // ----------------------------------------
  for (genvar c = 0; c < IPSE_NUM_INPUTS; c++) begin : g_contact
    ipse_contact u_contact (
      .i_core_clk(i_core_clk),
      .i_arst_n(i_arst_n),
      .i_ms_tick(ms_tick_r),
      .i_level(sync2_r[c]),
      .i_hold_wait_time(i_hold_wait_time),
      .i_hold_repeat_period(i_hold_repeat_period),
      .o_tap_event(o_tap_event[c]),
      .o_brief_press_event(o_brief_press_event[c]),
      .o_extended_press_event(o_extended_press_event[c]),
      .o_held_event(o_held_event[c]),
      .o_input_high_event(o_input_high_event[c]),
      .o_input_low_event(o_input_low_event[c])
    );
  end

  // ----------------------------------------
  // discovery flags
  // ----------------------------------------
  always_ff @(posedge i_core_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      o_discovered <= '0;
    end else if (i_discovery_strobe) begin
      o_discovered <= i_discovery_present;
    end
  end

  // ----------------------------------------
  // sensor channels, one per slot
  // ----------------------------------------
  // every slot is built even when empty; short only forces present ones
  for (genvar s = 0; s < IPSE_NUM_SENSORS; s++) begin : g_sensor
    ipse_sensor u_sensor (
      .i_core_clk(i_core_clk),
      .i_arst_n(i_arst_n),
      .i_valid(i_sensor_valid[s] && !i_bus_short),
      .i_value(i_sensor_value[s*IPSE_VAL_W +: IPSE_VAL_W]),
      .i_short(i_bus_short),
      .i_present(o_discovered[s]),
      .i_lower_limit(i_lower_limit),
      .i_upper_limit(i_upper_limit),
      .i_hyst_low(i_hyst_low),
      .i_hyst_high(i_hyst_high),
      .o_value(o_sensor_value[s*IPSE_VAL_W +: IPSE_VAL_W]),
      .o_value_changed_event(o_value_changed_event[s]),
      .o_rising_crossing_event(o_rising_crossing_event[s]),
      .o_falling_crossing_event(o_falling_crossing_event[s]),
      .o_out_of_limits_event(o_out_of_limits_event[s]),
      .o_back_in_limits_event(o_back_in_limits_event[s])
    );
  end

  // ----------------------------------------
  // checks
  // ----------------------------------------
  a_tick_spacing: assert property (@(posedge i_core_clk) disable iff (!i_arst_n)
    ms_tick_r && TICK_CYC > 1 |=> !ms_tick_r)
    else $error("tick pulses back to back");
  a_high_event_edge: assert property (@(posedge i_core_clk) disable iff (!i_arst_n)
    $rose(sync2_r[0]) |=> o_input_high_event[0])
    else $error("missing input-high event");
  a_high_event_ch1: assert property (@(posedge i_core_clk) disable iff (!i_arst_n)
    $rose(sync2_r[1]) |=> o_input_high_event[1])
    else $error("missing input-high event on second input");
  a_tap_after_low: assert property (@(posedge i_core_clk) disable iff (!i_arst_n)
    o_tap_event[1] |-> o_input_low_event[1])
    else $error("tap not at release");
  a_discovery_load: assert property (@(posedge i_core_clk) disable iff (!i_arst_n)
    i_discovery_strobe |=> o_discovered == $past(i_discovery_present))
    else $error("discovered flags not loaded");
  a_tap_excl_brief: assert property (@(posedge i_core_clk) disable iff (!i_arst_n)
    !(o_tap_event[0] && o_brief_press_event[0]))
    else $error("tap and brief press together");
  a_brief_after_low: assert property (@(posedge i_core_clk) disable iff (!i_arst_n)
    o_brief_press_event[0] |-> o_input_low_event[0])
    else $error("brief press not at release");
  a_ext_after_low: assert property (@(posedge i_core_clk) disable iff (!i_arst_n)
    o_extended_press_event[1] |-> o_input_low_event[1])
    else $error("extended press not at release");
  a_held_while_high: assert property (@(posedge i_core_clk) disable iff (!i_arst_n)
    o_held_event[0] |-> $past(sync2_r[0], 2))
    else $error("held event while input low");
endmodule

// [test/ipse_far_model.sv]
// far-side model: contact pins and temperature reading source
module ipse_far_model
  import ipse_pkg::*;
#(
  parameter int TICK_CYC = 4
)
(
  // clock
  input wire logic i_core_clk,
  // contact pins
  output logic [IPSE_NUM_INPUTS-1:0] o_contact,
  // sensor readings
  output logic [IPSE_NUM_SENSORS-1:0] o_valid,
  output logic [IPSE_NUM_SENSORS*IPSE_VAL_W-1:0] o_value,
  output logic o_short
);
  timeunit 1ns;
  timeprecision 1ps;

  initial begin
    o_contact = '0;
    o_valid = '0;
    o_value = '0;
    o_short = 1'b0;
  end

  // press held for ms ticks, then settle time for the release events
  task automatic press(input int ch, input int ms);
    o_contact[ch] = 1'b1;
    repeat (ms * TICK_CYC) @(posedge i_core_clk);
    #1 o_contact[ch] = 1'b0;
    repeat (8) @(posedge i_core_clk);
    #1;
  endtask

  // value line shows the inverse once valid drops, so a stale read shows up
  task automatic reading(input int s, input logic [IPSE_VAL_W-1:0] v);
    o_value[s*IPSE_VAL_W +: IPSE_VAL_W] = v;
    o_valid[s] = 1'b1;
    @(posedge i_core_clk);
    #1 o_valid[s] = 1'b0;
    o_value[s*IPSE_VAL_W +: IPSE_VAL_W] = ~v;
  endtask
endmodule

// [test/input_press_and_sensor_events_test.sv]
// testbench: press classification, held repeat and sensor events
module input_press_and_sensor_events_test;
  timeunit 1ns;
  timeprecision 1ps;
  import ipse_pkg::*;
  localparam int TICK = 4;
  localparam int WAIT = 1000;
  localparam int PER = 500;
  localparam int LO = 100;
  localparam int HI = 200;
  localparam int HL = 120;
  localparam int HH = 180;
  logic i_core_clk = 1'b0;
  logic i_arst_n = 1'b0;
  logic [1:0] pin, tap, brf, ext, hld, hi_ev, lo_ev, lvl;
  logic [3:0] vld, disc, chg, ris, fal, oor, bck;
  logic [3:0] pres = '0;
  logic strobe = 1'b0;
  logic sht;
  logic [63:0] val, sval;
  int err_total = 0;
  int checked = 0;
  int cnt[7][2];
  int ms_tab[6] = '{100, 600, 1900, 2100, 4900, 5100};
  logic [15:0] seq[8] = '{16'h0096, 16'h00be, 16'h00d2, 16'h00d2, 16'h0096, 16'h006e,
                          16'h005a, 16'h0096};
  logic [15:0] prv;
  logic o_p, a_p, b_p, o_n, a_n, b_n;

  always #5 i_core_clk = ~i_core_clk;

  ipse_far_model #(.TICK_CYC(TICK)) i_far (.i_core_clk(i_core_clk), .o_contact(pin),
    .o_valid(vld), .o_value(val), .o_short(sht));

  ipse_top #(.TICK_CYC(TICK)) i_dut (
    .i_core_clk(i_core_clk), .i_arst_n(i_arst_n), .i_contact_input_channel(pin),
    .i_hold_wait_time(16'(WAIT)), .i_hold_repeat_period(16'(PER)),
    .i_sensor_valid(vld), .i_sensor_value(val), .i_bus_short(sht),
    .i_discovery_strobe(strobe), .i_discovery_present(pres),
    .i_lower_limit(16'(LO)), .i_upper_limit(16'(HI)), .i_hyst_low(16'(HL)),
    .i_hyst_high(16'(HH)), .o_tap_event(tap), .o_brief_press_event(brf),
    .o_extended_press_event(ext), .o_held_event(hld), .o_input_high_event(hi_ev),
    .o_input_low_event(lo_ev), .o_contact_level(lvl), .o_discovered(disc),
    .o_sensor_value(sval), .o_value_changed_event(chg), .o_rising_crossing_event(ris),
    .o_falling_crossing_event(fal), .o_out_of_limits_event(oor),
    .o_back_in_limits_event(bck));

  // pulse tally per event kind and channel; for the level, a count of its high cycles
  always @(posedge i_core_clk) begin
    for (int c = 0; c < 2; c++) begin
      cnt[0][c] += (tap[c] === 1'b1);
      cnt[1][c] += (brf[c] === 1'b1);
      cnt[2][c] += (ext[c] === 1'b1);
      cnt[3][c] += (hld[c] === 1'b1);
      cnt[4][c] += (hi_ev[c] === 1'b1);
      cnt[5][c] += (lo_ev[c] === 1'b1);
      cnt[6][c] += (lvl[c] === 1'b1);
    end
  end

  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
    checked++;
    if (got !== exp) begin
      $display("ERROR %0t: %s got %h expected %h", $time, what, got, exp);
      err_total++;
    end
  endtask

  // boundaries kept clear of tick phase jitter
  function automatic int exp_ev(input int e, input int ms);
    case (e)
      0: return int'(ms < IPSE_TAP_MAX_MS);
      1: return int'(ms >= IPSE_TAP_MAX_MS && ms < IPSE_BRIEF_MAX_MS);
      2: return int'(ms >= IPSE_BRIEF_MAX_MS && ms <= IPSE_EXT_MAX_MS);
      3: return (ms < WAIT) ? 0 : (ms - WAIT) / PER + 1;
      6: return ms * TICK;
      default: return 1;
    endcase
  endfunction

  task automatic test_done();
    $display("comparisons %0d mismatches %0d", checked, err_total);
    if (err_total == 0 && checked > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask

  initial begin
    #900_000;
    err_total++;
    test_done();
  end

  initial begin
    repeat (3) @(posedge i_core_clk);
    #1 i_arst_n = 1'b1;
    @(posedge i_core_clk);
    #1;
    // ---------------------------------------------------------------
    // contact presses
    // ---------------------------------------------------------------
    for (int i = 0; i < 6; i++) begin
      cnt = '{default: 0};
      i_far.press(i % 2, ms_tab[i]);
      for (int e = 0; e < 7; e++) begin
        chk(32'(cnt[e][i % 2]), 32'(exp_ev(e, ms_tab[i])), "press events");
        chk(32'(cnt[e][1 - i % 2]), 32'h0, "idle channel events");
      end
    end
    // ---------------------------------------------------------------
    // sensor slots
    // ---------------------------------------------------------------
    for (int s = 0; s < 4; s++) begin
      for (int k = 0; k < 8; k++) begin
        i_far.reading(s, seq[k]);
        chk(32'(sval[s*16 +: 16]), 32'(seq[k]), "sensor value");
        o_n = (seq[k] < LO) || (seq[k] > HI);
        a_n = seq[k] > HH;
        b_n = seq[k] < HL;
        if (k > 0) begin
          chk({chg[s], ris[s], fal[s], oor[s], bck[s]}, {seq[k] != prv, a_n && !a_p,
            b_n && !b_p, o_n && !o_p, !o_n && o_p}, "sensor events");
        end
        prv = seq[k];
        o_p = o_n;
        a_p = a_n;
        b_p = b_n;
      end
    end
    pres = 4'h5;
    strobe = 1'b1;
    @(posedge i_core_clk);
    #1 strobe = 1'b0;
    @(posedge i_core_clk);
    #1 chk(32'(disc), 32'h5, "discovered flags");
    // short with a reading offered: reading ignored, present slots read zero
    i_far.o_short = 1'b1;
    i_far.reading(0, 16'h0033);
    @(posedge i_core_clk);
    #1 i_far.o_short = 1'b0;
    for (int s = 0; s < 4; s++) begin
      chk(32'(sval[s*16 +: 16]), (s % 2 == 0) ? 32'h0 : 32'h96, "short value");
    end
    // no further readings: last value kept
    repeat (20) @(posedge i_core_clk);
    #1 chk(32'(sval[16 +: 16]), 32'h96, "held value");
    chk(32'({chg, oor, bck}), 32'h0, "no disconnect events");
    test_done();
  end
endmodule
